/* File: src/sep_pkg.sv */
// package for the serial data memory port: register map, frame layout,
// opcodes, states and self-timed write timing.
// assumes a 50 MHz cpu clock and a free-running 15 ns memory timing clock.
package sep_pkg;
	// control register location and its bit positions
	localparam logic [7:0] CTRL_ADDR  = 8'h40;
	localparam int         SEL_BIT    = 4;
	localparam int         CLK_BIT    = 5;
	localparam int         DIN_BIT    = 6;
	localparam int         DOUT_BIT   = 7;
	localparam logic [3:0] UNUSED_LOW = 4'h0;

	// array and frame shape
	localparam int         MEM_WORDS      = 128;
	localparam int         ADDR_W         = 7;
	localparam int         DATA_W         = 8;
	localparam logic [3:0] LAST_FRAME_BIT = 4'h9;
	localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
	localparam logic [7:0] ERASED_WORD    = 8'hff;

	// opcodes and the sub-codes of the extended opcode
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_ERASE      = 2'h3;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_EXT        = 2'h0;
	localparam logic [1:0] EXT_ENABLE    = 2'h3;
	localparam logic [1:0] EXT_DISABLE   = 2'h0;
	localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EXT_WRITE_ALL = 2'h1;

	// self-timed cycle: longest time rounds down to whole timing clocks
	localparam int WRITE_TIME_NS  = 2000000;
	localparam int LINK_PERIOD_NS = 15;
	localparam int WRITE_CYCLES   = WRITE_TIME_NS / LINK_PERIOD_NS;

	// serial engine states, gray along idle-cmd-data-wait-busy
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_DATA   = 3'h3,
		ST_WAITCS = 3'h2,
		ST_BUSY   = 3'h6,
		ST_READ   = 3'h7
	} sep_state_t;

	// decoded instruction kinds
	typedef enum logic [2:0] {
		JOB_NONE      = 3'h0,
		JOB_READ      = 3'h1,
		JOB_ERASE     = 3'h2,
		JOB_WRITE     = 3'h3,
		JOB_ENABLE    = 3'h4,
		JOB_DISABLE   = 3'h5,
		JOB_ERASE_ALL = 3'h6,
		JOB_WRITE_ALL = 3'h7
	} sep_job_t;
endpackage : sep_pkg

/* File: src/sep_serial_port.sv */
// serial data memory port: cpu control register plus the 128x8 store
// with its three-wire serial engine on its own timing clock.
// assumes linkClk free-running; software bit-bangs select, clock, data-in.
//
// Notes on behaviour
// - store holds 128 bytes, read and written
// - control bits 0 to 3 read zero
// - bit 4 drives select, bit 5 clock
// - bit 6 drives data-in, bit 7 shows data-out
// - control register sits at address 40h
// - frame is start, two opcode, seven address
// - opcode and extended sub-code decoding
// - input bits captured on clock rising edge
// - data-out high whenever select low
// - programming disabled after power-up
// - changing instructions ignored while programming disabled
// - enable persists until disable or reset
// - read gives zero dummy then eight bits
// - reads work whether or not enabled
// - read address increments and wraps
// - erase starts on select fall, self-timed
// - write self-timed, erases before writing
// - data-out low while busy and selected, high after
// - erase-all sets every bit to one
// - write-all loads data byte everywhere
// - write cycle finishes within 2 ms
`timescale 1ns/1ps
`default_nettype none
module sep_serial_port #(
	parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       linkClk,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrEn,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData
);
	import sep_pkg::*;

	// ---------------- cpu side, ref_clk ----------------
	logic       selReg,  selNext;   // select line level
	logic       sclkReg, sclkNext;  // serial clock level
	logic       dinReg,  dinNext;   // serial data-in level
	logic [7:0] rdNext;             // next read answer
	logic       doutCpu;            // data-out seen on cpu clock

	// register write and read decode
	always_comb begin
		selNext  = selReg;
		sclkNext = sclkReg;
		dinNext  = dinReg;
		rdNext   = 8'h00;
		if (regWrEn && regAddr == CTRL_ADDR) begin
			selNext  = regWrData[SEL_BIT];
			sclkNext = regWrData[CLK_BIT];
			dinNext  = regWrData[DIN_BIT];
		end
		if (regRdEn && regAddr == CTRL_ADDR) begin
			rdNext = {doutCpu, dinReg, sclkReg, selReg, UNUSED_LOW};
		end
	end

	// cpu side registers
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			selReg    <= 1'b0;
			sclkReg   <= 1'b0;
			dinReg    <= 1'b0;
			regRdData <= 8'h00;
		end else begin
			selReg    <= selNext;
			sclkReg   <= sclkNext;
			dinReg    <= dinNext;
			regRdData <= rdNext;
		end
	end

	// ---------------- crossings ----------------
	logic       linkRstn; // reset as seen on the timing clock
	logic [2:0] lineSync; // select, clock, data-in on the timing clock
	logic       doutReg;  // data-out, timing clock domain

	sep_sync #(.WIDTH(1)) u_rst_sync (
		.clk    (linkClk),
		.asyncIn(resetn),
		.syncOut(linkRstn)
	);
	sep_sync #(.WIDTH(3)) u_line_sync (
		.clk    (linkClk),
		.asyncIn({dinReg, sclkReg, selReg}),
		.syncOut(lineSync)
	);
	sep_sync #(.WIDTH(1)) u_dout_sync (
		.clk    (ref_clk),
		.asyncIn(doutReg),
		.syncOut(doutCpu)
	);

	// ---------------- serial engine, linkClk ----------------
	logic                  csS, skS, diS;         // synchronised lines
	logic                  skPrevReg;             // last clock level
	logic                  skRise;                // clock rising edge seen
	sep_state_t            stateReg, stateNext;   // engine state
	sep_job_t              jobReg,   jobNext;     // pending instruction
	logic [3:0]            cntReg,   cntNext;     // bit counter
	logic [9:0]            frameReg, frameNext;   // shifted frame bits
	logic [9:0]            frameFull;             // frame incl. current bit
	logic [ADDR_W-1:0]     addrReg,  addrNext;    // word address
	logic [DATA_W-1:0]     dataReg,  dataNext;    // data byte shifted in
	logic [DATA_W-1:0]     outReg,   outNext;     // read byte being sent
	logic                  rbitReg,  rbitNext;    // read bit on data-out
	logic                  progEnReg, progEnNext; // programming enable latch
	logic                  doutNext;
	logic                  timerStart, timerDone;
	logic                  memWe;                 // array update this cycle
	logic [DATA_W-1:0]     memReg  [MEM_WORDS];   // the data store
	logic [DATA_W-1:0]     memNext [MEM_WORDS];

	assign {diS, skS, csS} = lineSync;
	assign skRise          = skS && !skPrevReg;
	assign frameFull       = {frameReg[8:0], diS};
	assign memWe           = (stateReg == ST_BUSY) && timerDone;

	// opcode and sub-code decoding
	function automatic sep_job_t decodeJob(input logic [9:0] f);
		sep_job_t j;
		j = JOB_NONE;
		case (f[8:7])
			OP_READ:  j = JOB_READ;
			OP_ERASE: j = JOB_ERASE;
			OP_WRITE: j = JOB_WRITE;
			OP_EXT: begin
				case (f[6:5])
					EXT_ENABLE:    j = JOB_ENABLE;
					EXT_DISABLE:   j = JOB_DISABLE;
					EXT_ERASE_ALL: j = JOB_ERASE_ALL;
					default:       j = JOB_WRITE_ALL;
				endcase
			end
			default:  j = JOB_NONE;
		endcase
		return j;
	endfunction : decodeJob

	sep_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
		.clk  (linkClk),
		.rstn (linkRstn),
		.start(timerStart),
		.done (timerDone)
	);

	// engine next state, array update and data-out
	always_comb begin
		stateNext  = stateReg;
		jobNext    = jobReg;
		cntNext    = cntReg;
		frameNext  = frameReg;
		addrNext   = addrReg;
		dataNext   = dataReg;
		outNext    = outReg;
		rbitNext   = rbitReg;
		progEnNext = progEnReg;
		timerStart = 1'b0;
		memNext    = memReg;
		case (stateReg)
			ST_IDLE: begin
				// select high opens a new frame
				if (csS) begin
					stateNext = ST_CMD;
					cntNext   = 4'h0;
				end
			end
			ST_CMD: begin
				if (!csS) begin
					stateNext = ST_IDLE; // abandoned frame
				end else if (skRise && (cntReg != 4'h0 || diS)) begin
					frameNext = frameFull;
					cntNext   = cntReg + 4'h1;
					if (cntReg == LAST_FRAME_BIT) begin
						jobNext  = decodeJob(frameFull);
						addrNext = frameFull[ADDR_W-1:0];
						cntNext  = 4'h0;
						case (decodeJob(frameFull))
							JOB_READ: begin
								stateNext = ST_READ;
								outNext   = memReg[frameFull[ADDR_W-1:0]];
								rbitNext  = 1'b0;
							end
							JOB_WRITE, JOB_WRITE_ALL: stateNext = ST_DATA;
							default:                  stateNext = ST_WAITCS;
						endcase
					end
				end
			end
			ST_DATA: begin
				if (!csS) begin
					stateNext = ST_IDLE;
				end else if (skRise) begin
					dataNext = {dataReg[DATA_W-2:0], diS};
					cntNext  = cntReg + 4'h1;
					if (cntReg == LAST_DATA_BIT) begin
						stateNext = ST_WAITCS;
					end
				end
			end
			ST_WAITCS: begin
				// select low executes the instruction
				if (!csS) begin
					stateNext = ST_IDLE;
					case (jobReg)
						JOB_ENABLE:  progEnNext = 1'b1;
						JOB_DISABLE: progEnNext = 1'b0;
						JOB_ERASE, JOB_WRITE, JOB_ERASE_ALL, JOB_WRITE_ALL: begin
							if (progEnReg) begin
								stateNext  = ST_BUSY;
								timerStart = 1'b1;
							end
						end
						default: stateNext = ST_IDLE;
					endcase
				end
			end
			ST_BUSY: begin
				// array changes when the self-timed cycle ends
				if (timerDone) begin
					stateNext = ST_IDLE;
					case (jobReg)
						JOB_ERASE: memNext[addrReg] = ERASED_WORD;
						JOB_WRITE: memNext[addrReg] = dataReg;
						JOB_ERASE_ALL: begin
							for (int i = 0; i < MEM_WORDS; i++) begin
								memNext[i] = ERASED_WORD;
							end
						end
						JOB_WRITE_ALL: begin
							for (int i = 0; i < MEM_WORDS; i++) begin
								memNext[i] = dataReg;
							end
						end
						default: stateNext = ST_IDLE;
					endcase
				end
			end
			ST_READ: begin
				if (!csS) begin
					stateNext = ST_IDLE;
				end else if (skRise) begin
					rbitNext = outReg[DATA_W-1];
					outNext  = {outReg[DATA_W-2:0], 1'b0};
					cntNext  = cntReg + 4'h1;
					if (cntReg == LAST_DATA_BIT) begin
						cntNext  = 4'h0;
						addrNext = addrReg + ADDR_W'(1);
						outNext  = memReg[addrReg + ADDR_W'(1)];
					end
				end
			end
			default: stateNext = ST_IDLE;
		endcase
		// data-out: ready high, busy low, read bits, high when deselected
		if (!csS) begin
			doutNext = 1'b1;
		end else if (stateReg == ST_BUSY) begin
			doutNext = 1'b0;
		end else if (stateReg == ST_READ) begin
			doutNext = rbitReg;
		end else begin
			doutNext = 1'b1;
		end
	end

	// engine registers, synchronous reset on the timing clock
	always_ff @(posedge linkClk) begin
		if (!linkRstn) begin
			stateReg  <= ST_IDLE;
			jobReg    <= JOB_NONE;
			cntReg    <= 4'h0;
			frameReg  <= 10'h000;
			addrReg   <= '0;
			dataReg   <= '0;
			outReg    <= '0;
			rbitReg   <= 1'b1;
			progEnReg <= 1'b0;
			skPrevReg <= 1'b0;
			doutReg   <= 1'b1;
		end else begin
			stateReg  <= stateNext;
			jobReg    <= jobNext;
			cntReg    <= cntNext;
			frameReg  <= frameNext;
			addrReg   <= addrNext;
			dataReg   <= dataNext;
			outReg    <= outNext;
			rbitReg   <= rbitNext;
			progEnReg <= progEnNext;
			skPrevReg <= skS;
			doutReg   <= doutNext;
		end
	end

	// the store keeps its contents through reset
	always_ff @(posedge linkClk) begin
		memReg <= memNext;
	end

	// ---------------- checks ----------------
	sequence s_exec_fall;
		stateReg == ST_WAITCS && !csS;
	endsequence
	sequence s_read_entry;
		stateReg != ST_READ ##1 stateReg == ST_READ && csS;
	endsequence

	property p_reg_write;
		@(posedge ref_clk) disable iff (!resetn)
		regWrEn && regAddr == CTRL_ADDR |=> selReg == $past(regWrData[SEL_BIT])
			&& sclkReg == $past(regWrData[CLK_BIT]) && dinReg == $past(regWrData[DIN_BIT]);
	endproperty
	a_reg_write: assert property (p_reg_write) else $error("control bits not taken");
	property p_low_zero;
		@(posedge ref_clk) disable iff (!resetn)
		regRdEn |=> regRdData[3:0] == UNUSED_LOW
			&& regRdData[SEL_BIT] == ($past(selReg) && $past(regAddr) == CTRL_ADDR);
	endproperty
	a_low_zero: assert property (p_low_zero) else $error("read answer wrong");
	property p_deselect_high;
		@(posedge linkClk) disable iff (!linkRstn)
		!csS |=> doutReg;
	endproperty
	a_deselect_high: assert property (p_deselect_high) else $error("data-out low unselected");
	property p_busy_low;
		@(posedge linkClk) disable iff (!linkRstn)
		stateReg == ST_BUSY && csS |=> !doutReg;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy not shown low");
	property p_locked;
		@(posedge linkClk) disable iff (!linkRstn)
		s_exec_fall and !progEnReg |=> stateReg == ST_IDLE && !timerDone [*2];
	endproperty
	a_locked: assert property (p_locked) else $error("change ran while disabled");
	property p_we_enabled;
		@(posedge linkClk) disable iff (!linkRstn)
		memWe |-> progEnReg && jobReg inside {JOB_ERASE, JOB_WRITE, JOB_ERASE_ALL, JOB_WRITE_ALL};
	endproperty
	a_we_enabled: assert property (p_we_enabled) else $error("array written unexpectedly");
	property p_enable_latch;
		@(posedge linkClk) disable iff (!linkRstn)
		s_exec_fall and jobReg == JOB_ENABLE |=> progEnReg;
	endproperty
	a_enable_latch: assert property (p_enable_latch) else $error("enable not latched");
	property p_dummy;
		@(posedge linkClk) disable iff (!linkRstn)
		s_read_entry |=> !doutReg;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy bit not zero");
	property p_addr_inc;
		@(posedge linkClk) disable iff (!linkRstn)
		stateReg == ST_READ && csS && skRise && cntReg == LAST_DATA_BIT
			|=> addrReg == $past(addrReg) + ADDR_W'(1);
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("read address not advanced");
	property p_erase_ones;
		@(posedge linkClk) disable iff (!linkRstn)
		memWe && jobReg == JOB_ERASE |=> memReg[addrReg] == ERASED_WORD && stateReg == ST_IDLE;
	endproperty
	a_erase_ones: assert property (p_erase_ones) else $error("erased word not all ones");
	property p_start_busy;
		@(posedge linkClk) disable iff (!linkRstn)
		s_exec_fall and progEnReg and jobReg == JOB_WRITE |=> stateReg == ST_BUSY [*2];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("write not started");
endmodule : sep_serial_port
`default_nettype wire

/* File: src/sep_sync.sv */
// two flip-flop level synchroniser, WIDTH independent bits.
// assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/1ps
`default_nettype none
module sep_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stageReg; // first stage, read only by the second

	if (WIDTH < 1) begin : g_bad_width
		$error("sep_sync width must be at least one");
	end

	// two stages, no reset so it can also carry a reset
	always_ff @(posedge clk) begin
		stageReg <= asyncIn;
		syncOut  <= stageReg;
	end
endmodule : sep_sync
`default_nettype wire

/* File: src/sep_timer.sv */
// self-timed cycle generator for erase and write.
// assumes start is a one-cycle pulse; done stands in the last of CYCLES cycles.
`timescale 1ns/1ps
`default_nettype none
module sep_timer #(
	parameter int CYCLES = 133333
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic start,
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cntReg;   // cycles still to run
	logic [CW-1:0] cntNext;

	if (CYCLES < 1) begin : g_bad_cycles
		$error("sep_timer needs at least one cycle");
	end

	// count down from CYCLES once started
	always_comb begin
		cntNext = cntReg;
		if (start) begin
			cntNext = CW'(CYCLES);
		end else if (cntReg != '0) begin
			cntNext = cntReg - CW'(1);
		end
	end

	// done in the last counted cycle, so busy spans exactly CYCLES clocks
	// and never runs past the longest allowed write time
	assign done = (cntReg == CW'(1));

	// register with synchronous reset
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cntReg <= '0;
		end else begin
			cntReg <= cntNext;
		end
	end
endmodule : sep_timer
`default_nettype wire

/* File: verification/sep_cpu_model.sv */
// software-side model: register accesses and bit-banged serial frames.
// assumes the control register at CTRL_ADDR and a ~120 ns level hold.
`timescale 1ns/1ps
`default_nettype none
module sep_cpu_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] regRdData,
	output logic      [7:0] regAddr,
	output logic            regWrEn,
	output logic      [7:0] regWrData,
	output logic            regRdEn
);
	import sep_pkg::*;

	// bus idle from time zero
	initial begin
		regAddr   = 8'h00;
		regWrEn   = 1'b0;
		regWrData = 8'h00;
		regRdEn   = 1'b0;
	end

	// one write strobe, then hold the level for the link side
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regAddr   = a;
		regWrData = d;
		regWrEn   = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask : wr

	// one read strobe, answer taken one cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge ref_clk);
		regRdEn = 1'b0;
		d       = regRdData;
	endtask : rd

	// set select, serial clock and data-in levels
	task automatic ctl(input logic cs, input logic sk, input logic di);
		wr(CTRL_ADDR, {1'b0, di, sk, cs, 4'h0});
	endtask : ctl

	// n bits msb first, data set before each clock rise
	task automatic clockIn(input logic [17:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			ctl(1'b1, 1'b0, b[i]);
			ctl(1'b1, 1'b1, b[i]);
		end
	endtask : clockIn

	// whole instruction, executed by dropping select
	task automatic instr(input logic [17:0] b, input int n);
		clockIn(b, n);
		ctl(1'b1, 1'b0, 1'b0);
		ctl(1'b0, 1'b0, 1'b0);
	endtask : instr

	// poll status with select high until ready, bounded
	task automatic ready(output logic first, output logic ok);
		logic [7:0] v;
		ctl(1'b1, 1'b0, 1'b0);
		repeat (3) @(negedge ref_clk);
		rd(CTRL_ADDR, v);
		first = v[DOUT_BIT];
		ok    = first;
		for (int i = 0; i < 60 && !ok; i++) begin
			rd(CTRL_ADDR, v);
			ok = v[DOUT_BIT];
		end
		ctl(1'b0, 1'b0, 1'b0);
	endtask : ready

	// read frame, dummy bit, then three streamed words
	task automatic readWords(input logic [6:0] a, output logic dmy, output logic [23:0] w);
		logic [7:0] v;
		clockIn({8'h00, 1'b1, OP_READ, a}, 10);
		rd(CTRL_ADDR, v);
		dmy = v[DOUT_BIT];
		for (int i = 23; i >= 0; i--) begin
			ctl(1'b1, 1'b0, 1'b0);
			ctl(1'b1, 1'b1, 1'b0);
			rd(CTRL_ADDR, v);
			w[i] = v[DOUT_BIT];
		end
		ctl(1'b1, 1'b0, 1'b0);
		ctl(1'b0, 1'b0, 1'b0);
	endtask : readWords
endmodule : sep_cpu_model
`default_nettype wire

/* File: verification/serial_eeprom_data_port_tb.sv */
// testbench for the serial data memory port: register and serial checks.
// assumes a shortened self-timed cycle of 20 link clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_data_port_tb;
	import sep_pkg::*;

	logic       ref_clk  = 1'b0; // cpu clock, 20 ns
	logic       linkClk  = 1'b0; // timing clock, 15 ns
	logic       resetn   = 1'b0; // active low reset
	logic [7:0] regAddr;         // bus from the model
	logic       regWrEn;
	logic [7:0] regWrData;
	logic       regRdEn;
	logic [7:0] regRdData;       // answer from the design
	int         nErrors  = 0;    // mismatch count
	int         testsRun = 0;    // comparison count

	// clocks, unrelated phase
	always #10 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #7.5 linkClk = ~linkClk;
	end

	sep_serial_port #(.WRITE_CYCLES(20)) sep_serial_port_i (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.linkClk   (linkClk),
		.regAddr   (regAddr),
		.regWrEn   (regWrEn),
		.regWrData (regWrData),
		.regRdEn   (regRdEn),
		.regRdData (regRdData)
	);

	sep_cpu_model sep_cpu_model_i (
		.ref_clk   (ref_clk),
		.regRdData (regRdData),
		.regAddr   (regAddr),
		.regWrEn   (regWrEn),
		.regWrData (regWrData),
		.regRdEn   (regRdEn)
	);

	// byte compare, counted
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// verdict and stop
	task automatic endOfTest;
		if (nErrors == 0 && testsRun > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : endOfTest

	// start bit, opcode, address
	function automatic logic [9:0] fr(input logic [1:0] op, input logic [6:0] a);
		return {1'b1, op, a};
	endfunction : fr

	// instruction then status: idle means no busy phase expected
	task automatic prog(input logic [17:0] b, input int n, input logic idle);
		logic first;
		logic ok;
		sep_cpu_model_i.instr(b, n);
		sep_cpu_model_i.ready(first, ok);
		check("status while selected", {7'h00, idle}, {7'h00, first});
		check("ready in time", 8'h01, {7'h00, ok});
	endtask : prog

	// streamed read of three words from a
	task automatic rdChk(input logic [6:0] a, input logic [23:0] exp);
		logic        dmy;
		logic [23:0] w;
		sep_cpu_model_i.readWords(a, dmy, w);
		check("dummy bit", 8'h00, {7'h00, dmy});
		check("word 0", exp[23:16], w[23:16]);
		check("word 1", exp[15:8], w[15:8]);
		check("word 2", exp[7:0], w[7:0]);
	endtask : rdChk

	// watchdog: the sequence needs about 4700 cycles, allow roughly four times that
	initial begin
		repeat (20000) @(posedge ref_clk);
		nErrors++;
		endOfTest();
	end

	// main sequence
	initial begin
		logic [7:0] v;
		repeat (8) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		sep_cpu_model_i.rd(CTRL_ADDR, v);
		check("ctrl after reset", 8'h80, v);
		sep_cpu_model_i.wr(8'h41, 8'h10);
		sep_cpu_model_i.rd(CTRL_ADDR, v);
		check("ctrl after stray write", 8'h80, v);
		sep_cpu_model_i.rd(8'h41, v);
		check("stray read", 8'h00, v);
		sep_cpu_model_i.wr(CTRL_ADDR, 8'h30);
		sep_cpu_model_i.rd(CTRL_ADDR, v);
		check("ctrl select clock", 8'h30, v & 8'h7f);
		sep_cpu_model_i.wr(CTRL_ADDR, 8'h40);
		sep_cpu_model_i.rd(CTRL_ADDR, v);
		check("ctrl data in", 8'hc0, v);
		sep_cpu_model_i.wr(CTRL_ADDR, 8'h00);
		prog({8'h00, fr(OP_EXT, {EXT_ERASE_ALL, 5'h00})}, 10, 1'b1);
		prog({8'h00, fr(OP_EXT, {EXT_ENABLE, 5'h00})}, 10, 1'b1);
		prog({8'h00, fr(OP_EXT, {EXT_ERASE_ALL, 5'h00})}, 10, 1'b0);
		rdChk(7'h00, 24'hffffff);
		prog({fr(OP_WRITE, 7'h7f), 8'h3c}, 18, 1'b0);
		prog({fr(OP_WRITE, 7'h00), 8'hc3}, 18, 1'b0);
		rdChk(7'h7f, 24'h3cc3ff);
		prog({8'h00, fr(OP_ERASE, 7'h00)}, 10, 1'b0);
		rdChk(7'h7e, 24'hff3cff);
		prog({fr(OP_EXT, {EXT_WRITE_ALL, 5'h00}), 8'ha5}, 18, 1'b0);
		prog({fr(OP_WRITE, 7'h40), 8'h5a}, 18, 1'b0);
		rdChk(7'h3f, 24'ha55aa5);
		prog({8'h00, fr(OP_EXT, {EXT_DISABLE, 5'h00})}, 10, 1'b1);
		prog({fr(OP_WRITE, 7'h40), 8'h00}, 18, 1'b1);
		prog({8'h00, fr(OP_ERASE, 7'h40)}, 10, 1'b1);
		prog({8'h00, fr(OP_EXT, {EXT_ERASE_ALL, 5'h00})}, 10, 1'b1);
		rdChk(7'h40, 24'h5aa5a5);
		endOfTest();
	end
endmodule : serial_eeprom_data_port_tb
`default_nettype wire
